// ---- fph_defines.svh ----
// Offsets, field positions, reset values and timing counts of the FIR phase and high-pass stage
`ifndef FPH_DEFINES_SVH
`define FPH_DEFINES_SVH

`define FPH_ADDR_W 4
`define FPH_REG_CTRL 4'h0
`define FPH_REG_HPF_LO 4'h1
`define FPH_REG_HPF_HI 4'h2
`define FPH_REG_STATUS 4'h3

`define FPH_CTRL_PATH_LSB 0
`define FPH_CTRL_PHASE_BIT 2

`define FPH_ST_MODE_BIT 0
`define FPH_ST_PHASE_BIT 1
`define FPH_ST_HP_BIT 2
`define FPH_ST_PATH_LSB 3

`define FPH_RST_PATH 2'h3
`define FPH_RST_PHASE 1'h0
`define FPH_RST_COEFF 16'h0337
`define FPH_PIN_COEFF 16'h0332

`define FPH_MCLK_HZ 250000000
`define FPH_MOD_DIV 4
`define FPH_MOD_CNT_W 2

`endif

// ---- fph_partner.sv ----
// Far-side model: upstream sample source and downstream sink
`timescale 1ns/100ps
`default_nettype none
module fph_partner
  import fph_pkg::*;
(
  // Clock and flow control
  input wire logic mclk,
  input wire logic stall,
  // Samples toward the stage
  output logic in_valid,
  output logic signed [23:0] in_data,
  input wire logic in_ready,
  // Samples from the stage
  input wire logic out_valid,
  input wire logic signed [29:0] out_data,
  output logic out_ready
);
  logic signed [23:0] src_q[$];
  logic [29:0] rx_q[$];

  initial
  begin
    in_valid = 1'b0;
    in_data = 24'h00_0000;
    out_ready = 1'b0;
  end

  always @(posedge mclk)
  begin
    if (in_valid && in_ready)
      void'(src_q.pop_front());
    if (src_q.size() > 0)
    begin
      in_valid <= 1'b1;
      in_data <= src_q[0];
    end
    else
    begin
      // Idle bus must not look like a held word
      in_valid <= 1'b0;
      in_data <= ~in_data;
    end
    if (out_valid && out_ready)
      rx_q.push_back(out_data);
    out_ready <= !stall;
  end
endmodule // fph_partner
`default_nettype wire

// ---- fph_pkg.sv ----
// Types shared by the FIR phase and high-pass stage
package fph_pkg;

  typedef enum logic [1:0] {
    FPH_PATH_BYPASS = 2'b00,
    FPH_PATH_SINC = 2'b01,
    FPH_PATH_LOWPASS = 2'b10,
    FPH_PATH_FULL = 2'b11
  } fph_path_t;

  typedef struct packed {
    fph_path_t path;
    logic phase;
    logic [15:0] coeff;
  } fph_cfg_t;

endpackage

// ---- fph_stage.sv ----
// FIR phase selection, first-order high-pass stage, mode select and output buffer
//
// How it works
// - Phase comes from register bit or phase pin; 0 linear, 1 minimum.
// - Both phase taps share the same magnitude response; only phase differs.
// - Linear phase taps are symmetric, so delay is constant over frequency.
// - Linear phase has longer group delay and settling than minimum phase.
// - High-pass: first difference times (2-a)/2 plus b times previous output.
// - High-pass fully rejects dc and attenuates below the corner.
// - In pin mode the coefficient is fixed at 0332h.
// - Control mode high: configuration from pins, no programmable registers.
// - Control mode low: path, phase and coefficient from configuration registers.
// - All timing derives from the master clock.
// - High-pass runs only on the full path, else it is bypassed.
// - Modulator sample rate is the master clock divided by four.
//
// Design decisions made here: the address map and the strobed register port.
`include "fph_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module fph_stage
  import fph_pkg::*;
#(
  parameter int DW = 24
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port
  input wire logic [`FPH_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [7:0] reg_rdata,
  // Mode pins
  input wire logic control_mode_select,
  input wire logic phase_or_modclk_pin,
  input wire logic highpass_or_sync_pin,
  // Samples from the decimator
  input wire logic in_valid,
  input wire logic signed [DW-1:0] in_data,
  output logic in_ready,
  // Samples toward output code processing
  output logic out_valid,
  output logic signed [DW+5:0] out_data,
  input wire logic out_ready,
  // Modulator sample strobe
  output logic mod_tick
);

  localparam int FW = DW + 4;
  localparam int OW = DW + 6;
  localparam int PW = DW + 25;

  fph_path_t path_reg;
  logic phase_reg;
  logic [15:0] coeff_reg;
  fph_cfg_t cfg;
  logic hp_active;

  logic signed [DW-1:0] x1;
  logic signed [DW-1:0] x2;
  logic signed [FW-1:0] hp_x_prev;
  logic signed [OW-1:0] hp_y_prev;

  logic [`FPH_MOD_CNT_W-1:0] mod_cnt;

  logic signed [OW-1:0] buf_mem [2];
  logic buf_wp;
  logic buf_rp;
  logic [1:0] buf_cnt;

  // Effective configuration
  always_comb
  begin
    if (control_mode_select)
    begin
      // Pin mode ignores anything software left in the registers
      cfg.path = highpass_or_sync_pin ? FPH_PATH_FULL : FPH_PATH_LOWPASS;
      cfg.phase = phase_or_modclk_pin;
      cfg.coeff = `FPH_PIN_COEFF;
    end
    else
    begin
      cfg.path = path_reg;
      cfg.phase = phase_reg;
      cfg.coeff = coeff_reg;
    end
  end

  assign hp_active = (cfg.path == FPH_PATH_FULL);

  // Register writes
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      path_reg <= fph_path_t'(`FPH_RST_PATH);
      phase_reg <= `FPH_RST_PHASE;
      coeff_reg <= `FPH_RST_COEFF;
    end
    else if (reg_we && !control_mode_select)
    begin
      case (reg_addr)
        `FPH_REG_CTRL:
        begin
          path_reg <= fph_path_t'(reg_wdata[`FPH_CTRL_PATH_LSB +: 2]);
          phase_reg <= reg_wdata[`FPH_CTRL_PHASE_BIT];
        end
        `FPH_REG_HPF_LO: coeff_reg[7:0] <= reg_wdata;
        `FPH_REG_HPF_HI: coeff_reg[15:8] <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Register reads, one cycle after the strobe
  logic [7:0] next_rdata;
  always_comb
  begin
    next_rdata = 8'h00;
    case (reg_addr)
      `FPH_REG_CTRL:
      begin
        if (!control_mode_select)
        begin
          next_rdata[`FPH_CTRL_PATH_LSB +: 2] = path_reg;
          next_rdata[`FPH_CTRL_PHASE_BIT] = phase_reg;
        end
      end
      `FPH_REG_HPF_LO: next_rdata = control_mode_select ? 8'h00 : coeff_reg[7:0];
      `FPH_REG_HPF_HI: next_rdata = control_mode_select ? 8'h00 : coeff_reg[15:8];
      `FPH_REG_STATUS:
      begin
        next_rdata[`FPH_ST_MODE_BIT] = control_mode_select;
        next_rdata[`FPH_ST_PHASE_BIT] = cfg.phase;
        next_rdata[`FPH_ST_HP_BIT] = hp_active;
        next_rdata[`FPH_ST_PATH_LSB +: 2] = cfg.path;
      end
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= reg_re ? next_rdata : 8'h00;
  end

  // Modulator strobe: one pulse every four master clocks
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      mod_cnt <= '0;
      mod_tick <= 1'b0;
    end
    else
    begin
      mod_cnt <= mod_cnt + 1'b1;
      mod_tick <= (mod_cnt == `FPH_MOD_CNT_W'(`FPH_MOD_DIV - 1));
    end
  end

  // FIR section
  logic push;
  logic pop;
  logic signed [FW-1:0] e0;
  logic signed [FW-1:0] e1;
  logic signed [FW-1:0] e2;
  logic signed [FW-1:0] fir_lin;
  logic signed [FW-1:0] fir_min;
  logic signed [FW-1:0] fir_out;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign e0 = {{4{in_data[DW-1]}}, in_data};
  assign e1 = {{4{x1[DW-1]}}, x1};
  assign e2 = {{4{x2[DW-1]}}, x2};
  // Zeros at -1/2 and -2 versus a double zero at -1/2 with gain four: same magnitude
  assign fir_lin = (e0 <<< 1) + (e1 <<< 2) + e1 + (e2 <<< 1);
  assign fir_min = (e0 <<< 2) + (e1 <<< 2) + e2;
  assign fir_out = cfg.phase ? fir_min : fir_lin;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      x1 <= '0;
      x2 <= '0;
    end
    else if (push)
    begin
      x1 <= in_data;
      x2 <= x1;
    end
  end

  // High-pass section, coefficients in unsigned Q16
  logic [16:0] one_m_a;
  logic [33:0] sq;
  logic [17:0] b_sum;
  logic [16:0] b_q;
  logic [16:0] k_q;
  logic signed [FW:0] hp_d;
  logic signed [PW-1:0] p_k;
  logic signed [PW-1:0] p_b;
  logic signed [PW-1:0] hp_sum;
  logic signed [OW-1:0] hp_y;
  logic signed [OW-1:0] result;

  assign one_m_a = 17'h1_0000 - {1'b0, cfg.coeff};
  assign sq = one_m_a * one_m_a;
  assign b_sum = 18'h1_0000 + {1'b0, sq[32:16]};
  assign b_q = b_sum[17:1];
  assign k_q = 17'h1_0000 - {2'b00, cfg.coeff[15:1]};
  // First difference puts a zero at dc, so a constant input decays to nothing
  assign hp_d = {fir_out[FW-1], fir_out} - {hp_x_prev[FW-1], hp_x_prev};
  assign p_k = $signed({1'b0, k_q}) * hp_d;
  assign p_b = $signed({1'b0, b_q}) * hp_y_prev;
  assign hp_sum = p_k + p_b;
  assign hp_y = hp_sum[OW+15:16];

  always_comb
  begin
    case (cfg.path)
      FPH_PATH_FULL: result = hp_y;
      FPH_PATH_LOWPASS: result = {{2{fir_out[FW-1]}}, fir_out};
      default: result = {{6{in_data[DW-1]}}, in_data};
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      hp_x_prev <= '0;
      hp_y_prev <= '0;
    end
    else if (push)
    begin
      hp_x_prev <= fir_out;
      // Bypassed stage clears its output history, so it restarts clean
      hp_y_prev <= hp_active ? hp_y : '0;
    end
  end

  // Two-entry output buffer
  logic [1:0] next_cnt;
  logic next_rp;
  logic signed [OW-1:0] next_mem [2];

  always_comb
  begin
    next_mem[0] = buf_mem[0];
    next_mem[1] = buf_mem[1];
    if (push)
      next_mem[buf_wp] = result;
    next_rp = pop ? ~buf_rp : buf_rp;
    next_cnt = buf_cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      buf_mem[0] <= '0;
      buf_mem[1] <= '0;
      buf_wp <= 1'b0;
      buf_rp <= 1'b0;
      buf_cnt <= 2'd0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
      out_data <= '0;
    end
    else
    begin
      buf_mem[0] <= next_mem[0];
      buf_mem[1] <= next_mem[1];
      buf_wp <= push ? ~buf_wp : buf_wp;
      buf_rp <= next_rp;
      buf_cnt <= next_cnt;
      // Ready drops as soon as both entries hold data, so a stall loses nothing
      in_ready <= (next_cnt != 2'd2);
      out_valid <= (next_cnt != 2'd0);
      out_data <= next_mem[next_rp];
    end
  end

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence tick_s;
    mod_tick;
  endsequence
  sequence quiet3_s;
    !mod_tick [*3];
  endsequence

  mod_period_a: assert property (tick_s |=> quiet3_s ##1 tick_s)
    else $error("modulator strobe period is not four clocks");
  pin_coeff_a: assert property (control_mode_select |-> cfg.coeff == 16'h0332)
    else $error("pin mode coefficient wrong");
  pin_phase_a: assert property (control_mode_select
    |-> cfg.phase == phase_or_modclk_pin)
    else $error("pin mode phase not taken from pin");
  write_locked_a: assert property (control_mode_select && reg_we
    |=> $stable(coeff_reg) && $stable(path_reg) && $stable(phase_reg))
    else $error("register changed in pin mode");
  write_taken_a: assert property (!control_mode_select && reg_we
    && reg_addr == `FPH_REG_CTRL
    |=> path_reg == $past(reg_wdata[1:0]) && phase_reg == $past(reg_wdata[2]))
    else $error("control write not taken");
  // Both coefficient bytes land on their own, no paired commit
  coeff_lo_a: assert property (!control_mode_select && reg_we
    && reg_addr == `FPH_REG_HPF_LO |=> coeff_reg[7:0] == $past(reg_wdata))
    else $error("low coefficient byte not taken");
  coeff_hi_a: assert property (!control_mode_select && reg_we
    && reg_addr == `FPH_REG_HPF_HI |=> coeff_reg[15:8] == $past(reg_wdata))
    else $error("high coefficient byte not taken");
  dc_reject_a: assert property (push && hp_active && hp_y_prev == 0
    && fir_out == hp_x_prev |-> hp_y == 0)
    else $error("dc not rejected");
  bypass_hp_a: assert property (push && cfg.path == FPH_PATH_LOWPASS
    |=> hp_y_prev == 0)
    else $error("high-pass not bypassed");
  pin_path_a: assert property (control_mode_select
    |-> hp_active == highpass_or_sync_pin)
    else $error("pin mode high-pass select wrong");
  reg_phase_a: assert property (!control_mode_select
    |-> cfg.phase == phase_reg)
    else $error("register mode phase not from register");
  status_read_a: assert property (reg_re && reg_addr == `FPH_REG_STATUS
    |=> reg_rdata[0] == $past(control_mode_select))
    else $error("status read wrong");
  // Read data stand one cycle only, so a stale byte never looks fresh
  rdata_idle_a: assert property (!reg_re |=> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  same_gain_a: assert property (push && x1 == 0 && x2 == 0
    |-> fir_lin + fir_lin == fir_min)
    else $error("phase variants disagree on leading tap");
  buf_bound_a: assert property (buf_cnt == 2'd2 |-> !in_ready)
    else $error("buffer accepts while full");
  // A stalled sink must see the same word until it takes it
  out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("output word changed while stalled");
  ready_refill_a: assert property (buf_cnt == 2'd2 && pop |=> in_ready)
    else $error("ready not restored after drain");

endmodule // fph_stage

`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the FIR phase and high-pass stage
`timescale 1ns/100ps
`default_nettype none
module testbench
  import fph_pkg::*;
;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic mode = 1'b0;
  logic ph_pin = 1'b0;
  logic hp_pin = 1'b0;
  logic stall = 1'b0;
  logic [7:0] reg_rdata;
  logic in_valid, in_ready, out_valid, out_ready, mod_tick;
  logic signed [23:0] in_data;
  logic signed [29:0] out_data;
  int n_fail = 0;
  int checks = 0;
  int nt;
  longint h1 = 0, h2 = 0, fp = 0, yp = 0;
  logic [29:0] exp_q[$];

  always #2 mclk = ~mclk;

  fph_stage #(.DW(24)) dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .control_mode_select(mode), .phase_or_modclk_pin(ph_pin),
    .highpass_or_sync_pin(hp_pin), .in_valid(in_valid), .in_data(in_data),
    .in_ready(in_ready), .out_valid(out_valid), .out_data(out_data),
    .out_ready(out_ready), .mod_tick(mod_tick));

  fph_partner u_far (.mclk(mclk), .stall(stall), .in_valid(in_valid), .in_data(in_data),
    .in_ready(in_ready), .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready));

  task automatic chk(input logic [29:0] got, input logic [29:0] want);
    checks++;
    if (got !== want)
    begin
      n_fail++;
      $display("FAIL %0t got %h want %h", $time, got, want);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_we <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] want);
    @(posedge mclk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_re <= 1'b0;
    #1;
    chk(30'(reg_rdata), 30'(want));
  endtask

  // Reference path: FIR history moves on every take, high-pass only on the full path;
  // while bypassed the high-pass input history still follows the FIR output
  function automatic longint model(longint x, logic [1:0] path, logic ph, longint a);
    longint f, y;
    f = ph ? 4 * x + 4 * h1 + h2 : 2 * x + 5 * h1 + 2 * h2;
    h2 = h1;
    h1 = x;
    if (path != 2'b11)
    begin
      fp = f;
      yp = 0;
      return path[1] ? f : x;
    end
    y = ((65536 - a / 2) * (f - fp) + ((65536 + (((65536 - a) ** 2) >> 16)) / 2) * yp) >>> 16;
    fp = f;
    yp = y;
    return y;
  endfunction

  task automatic run(input logic [1:0] path, input logic ph, input longint a,
                     input longint xs[$]);
    @(posedge mclk);
    #1;
    foreach (xs[k])
    begin
      u_far.src_q.push_back(24'(xs[k]));
      exp_q.push_back(30'(model(xs[k], path, ph, a)));
    end
    for (int w = 0; w < 200 && u_far.rx_q.size() < exp_q.size(); w++)
      @(posedge mclk);
    #1;
    while (exp_q.size() > 0)
      chk(u_far.rx_q.size() > 0 ? u_far.rx_q.pop_front() : 'x, exp_q.pop_front());
  endtask

  task automatic report_and_stop;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    #80000;
    n_fail++;
    report_and_stop();
  end

  initial
  begin
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    rd(4'h0, 8'h03);
    rd(4'h1, 8'h37);
    rd(4'h2, 8'h03);
    rd(4'h3, 8'h1c);
    rd(4'h7, 8'h00);
    nt = 0;
    repeat (40)
    begin
      @(posedge mclk);
      #1;
      nt += (mod_tick === 1'b1);
    end
    chk(30'(nt), 30'd10);
    wr(4'h0, 8'h00);
    run(2'b00, 1'b0, 0, '{5, -7});
    wr(4'h0, 8'h02);
    run(2'b10, 1'b0, 0, '{0, 0, 100, 100, 100});
    wr(4'h0, 8'h06);
    run(2'b10, 1'b1, 0, '{0, 0, 100, 100, 100});
    wr(4'h0, 8'h03);
    wr(4'h1, 8'h9a);
    wr(4'h2, 8'h01);
    run(2'b11, 1'b0, 410, '{0, 0, 1000, 1000, 1000, 1000, 1000, 1000});
    // Stalled sink: buffer must fill, refuse, then drain in order
    wr(4'h0, 8'h00);
    stall <= 1'b1;
    fork
      run(2'b00, 1'b0, 0, '{11, 12, 13, 14});
      begin
        repeat (10) @(posedge mclk);
        #1;
        chk(30'(in_ready), 30'h0);
        stall <= 1'b0;
      end
    join
    @(posedge mclk);
    mode <= 1'b1;
    hp_pin <= 1'b1;
    ph_pin <= 1'b1;
    wr(4'h0, 8'h07);
    rd(4'h0, 8'h00);
    rd(4'h3, 8'h1f);
    run(2'b11, 1'b1, 'h332, '{0, 0, 500, 500, 500, 500});
    @(posedge mclk);
    hp_pin <= 1'b0;
    rd(4'h3, 8'h13);
    run(2'b10, 1'b1, 0, '{300, 300, 300});
    @(posedge mclk);
    mode <= 1'b0;
    rd(4'h0, 8'h00);
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
